// file: rtl/adaptor_err_regs.svh
// register offsets, field positions and timing counts of the adaptor error and diagnostic block
`ifndef ADAPTOR_ERR_REGS_SVH
`define ADAPTOR_ERR_REGS_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_STATUS 12'h008
`define OFS_DIAG 12'h00C
`define OFS_MCAP_A 12'h010
`define OFS_ACAP_A 12'h014
`define OFS_MCAP_B 12'h018
`define OFS_ACAP_B 12'h01C

// ****************************************
// status bit positions
// ****************************************
`define ST_READ_TIMEOUT 10
`define ST_SUBSTITUTE 9
`define ST_CORRECTED 8
`define ST_CMD_ERROR 7
`define ST_CMD_TIMEOUT 6
`define ST_PATH_PARITY 5
`define ST_INVALID_MAP 4
`define ST_MAP_PARITY 3
`define ST_LOST_ERROR 2
`define ST_SELECT_TIMEOUT 1
`define ST_SSYNC_TIMEOUT 0
`define ST_WIDTH 11
`define ST_DMA_GROUP 11'h6F8
`define ST_SW_GROUP 11'h003
`define ST_RESET 11'h000

// ****************************************
// diagnostic bits and control register bits
// ****************************************
`define DG_SPARE 31
`define DG_INTR_IGNORE 30
`define DG_MAP_PAR_DEFEAT 29
`define DG_PATH_PAR_DEFEAT 28
`define DG_LSB 28
`define DG_RESET 4'h0
`define CR_DMA_IRQ_EN 4
`define CR_SW_IRQ_EN 3
`define CR_MAP_DIS_LSB 26
`define MAP_GROUP_SHIFT 4

// ****************************************
// timing: figures in ns, counts rounded up
// ****************************************
`define CLK_PERIOD_NS 20
`define READ_TMO_NS 100000
`define CMD_TMO_NS 100000
`define SELECT_TMO_NS 50000
`define SSYNC_TMO_NS 12800
`define NS_TO_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_TMO_CYC `NS_TO_CYC(`READ_TMO_NS)
`define CMD_TMO_CYC `NS_TO_CYC(`CMD_TMO_NS)
`define SELECT_TMO_CYC `NS_TO_CYC(`SELECT_TMO_NS)
`define SSYNC_TMO_CYC `NS_TO_CYC(`SSYNC_TMO_NS)

`endif

// file: rtl/adaptor_err_pkg.sv
// types shared by the adaptor error and diagnostic block
package adaptor_err_pkg;

   // kind of adaptor operation owning the current system-bus command
   typedef enum logic [2:0] {
      OP_DIRECT,
      OP_BUF_READ,
      OP_BUF_WRITE,
      OP_PURGE,
      OP_PREFETCH
   } op_kind_t;

   // register port request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   // system-bus responses for the dma side, one-cycle pulses
   typedef struct packed {
      logic cmd_ack;
      logic cmd_err;
      logic rd_data_ok;
      logic rd_substitute;
      logic rd_corrected;
   } sbi_resp_t;

   // dma-side context from the transfer sequencer
   typedef struct packed {
      op_kind_t op;
      logic cmd_sent;
      logic cmd_is_read;
      logic dev_timed_out;
      logic map_check;
      logic [8:0] map_index;
      logic map_valid;
      logic [15:0] map_hi;
      logic [1:0] map_par;
      logic path_check;
      logic [31:0] path_data;
      logic [3:0] path_par;
   } dma_ctx_t;

   // software-initiated transfer context
   typedef struct packed {
      logic npr_issued;
      logic bus_granted;
      logic msyn_start;
      logic ssyn_seen;
      logic [15:0] addr_hi;
   } sw_ctx_t;

endpackage

// file: rtl/err_timeout_timer.sv
// one restartable timeout counter giving a single expiry pulse
`timescale 1ns/1ps
module err_timeout_timer #(
   parameter int CYCLES = 640,
   parameter int W = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clr,
   input wire logic start,
   input wire logic stop,
   output logic expired
);

   typedef struct packed {
      logic busy;
      logic [W-1:0] cnt;
      logic expired;
   } tmr_state_t;

   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   tmr_state_t s_reg;
   tmr_state_t s_next;

   // stop beats start so a reply in the same cycle never arms a stale wait
   always_comb begin
      s_next = s_reg;
      s_next.expired = 1'b0;
      if (clr || stop) begin
         s_next.busy = 1'b0;
         s_next.cnt = '0;
      end else if (start) begin
         s_next.busy = 1'b1;
         s_next.cnt = '0;
      end else if (s_reg.busy) begin
         if (s_reg.cnt == LAST) begin
            s_next.busy = 1'b0;
            s_next.expired = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign expired = s_reg.expired;

endmodule // err_timeout_timer

// file: rtl/adaptor_error_diag_status.sv
// error status, failure capture and diagnostic control of the bus adaptor
//
// Notes on behaviour
// RULE_01 - dma read unanswered 100 us sets read timeout
// RULE_02 - substitute response sets flag, data withheld
// RULE_03 - corrected dma read data sets corrected flag
// RULE_04 - error confirmation sets command error, not prefetch
// RULE_05 - command stuck 100 us sets command timeout
// RULE_06 - buffered path parity error sets path flag
// RULE_07 - unvalidated, undisabled map entry sets invalid flag
// RULE_08 - map upper half parity error sets flag
// RULE_09 - seven dma flags lock each other, freeze entry
// RULE_10 - dma group flag requests interrupt when enabled
// RULE_11 - error while locked sets lost flag, no interrupt
// RULE_12 - no bus mastership 50 us sets select timeout
// RULE_13 - no slave reply 12.8 us sets sync timeout
// RULE_14 - two timeout flags lock; write one clears
// RULE_15 - software group flag interrupts when enabled
// RULE_16 - software timeout freezes failed address capture
// RULE_17 - spare diagnostic bit, cleared by init events
// RULE_18 - diagnostic bit ignores peripheral interrupt requests
// RULE_19 - diagnostic bit zeroes map parity bits checked
// RULE_20 - odd parity per byte plus parity bit
// RULE_21 - diagnostic bit blocks path parity bits checked
// RULE_22 - writing zero leaves error flags unchanged
// RULE_23 - control bit 4 dma, bit 3 software enable
// RULE_24 - interrupt held while enabled and flag set
`timescale 1ns/1ps
`include "adaptor_err_regs.svh"
module adaptor_error_diag_status import adaptor_err_pkg::*; #(
   parameter int READ_TMO_CYC = `READ_TMO_CYC,
   parameter int CMD_TMO_CYC = `CMD_TMO_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic adaptor_init,
   input wire logic bus_dead,
   input wire logic [31:0] control_reg,
   input wire reg_req_t reg_req,
   input wire sbi_resp_t sbi_resp,
   input wire dma_ctx_t dma_ctx,
   input wire sw_ctx_t sw_ctx,
   output logic [31:0] reg_rdata,
   output logic reg_err,
   output logic dma_err_irq,
   output logic sw_err_irq,
   output logic interrupt_ignore_bit,
   output logic read_data_suppress,
   output logic [8:0] failed_map_entry_capture,
   output logic [15:0] failed_address_capture
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      // sticky error flags
      logic [`ST_WIDTH-1:0] status;
      logic [3:0] diag;
      // captures freeze while their group is locked
      logic [8:0] mcap;
      logic [15:0] acap;
      logic [31:0] rdata;
      logic err;
      logic dma_irq;
      logic sw_irq;
      logic suppress;
   } blk_state_t;

   blk_state_t s_reg;
   blk_state_t s_next;

   localparam int N_TMR = 4;

   localparam int T_READ = 0;
   localparam int T_CMD = 1;
   localparam int T_SEL = 2;
   localparam int T_SSYN = 3;

   logic init_clr;

   // timer handshakes, one bit per wait
   logic [N_TMR-1:0] tmr_start;
   logic [N_TMR-1:0] tmr_stop;
   logic [N_TMR-1:0] tmr_exp;

   logic [1:0] map_byte_bad;
   logic [3:0] path_byte_bad;
   logic [1:0] map_par_seen;
   logic [3:0] path_par_seen;

   logic map_disabled;
   logic [9:0] map_dis_limit;

   logic [`ST_WIDTH-1:0] dma_ev;
   logic [`ST_WIDTH-1:0] sw_ev;

   logic not_prefetch;
   logic dma_read_op;

   // adaptor init and bus dead act like power-up on the volatile bits
   assign init_clr = adaptor_init | bus_dead; // RULE_17

   assign not_prefetch = (dma_ctx.op != OP_PREFETCH);
   assign dma_read_op = (dma_ctx.op == OP_DIRECT) || (dma_ctx.op == OP_BUF_READ);

   // ****************************************
   // timeout timers
   // ****************************************

   // read data wait: armed once a dma read command is accepted, never for prefetch
   assign tmr_start[T_READ] = sbi_resp.cmd_ack & dma_ctx.cmd_is_read & dma_read_op; // RULE_01
   assign tmr_stop[T_READ] = sbi_resp.rd_data_ok | sbi_resp.rd_substitute | sbi_resp.rd_corrected |
                             dma_ctx.dev_timed_out;

   // command wait: from issue to any confirmation
   assign tmr_start[T_CMD] = dma_ctx.cmd_sent;
   assign tmr_stop[T_CMD] = sbi_resp.cmd_ack | sbi_resp.cmd_err;

   // select wait: npr issued until mastership is won
   assign tmr_start[T_SEL] = sw_ctx.npr_issued; // RULE_12
   assign tmr_stop[T_SEL] = sw_ctx.bus_granted;

   // slave sync wait: data cycle start until the slave answers
   assign tmr_start[T_SSYN] = sw_ctx.msyn_start; // RULE_13
   assign tmr_stop[T_SSYN] = sw_ctx.ssyn_seen;

   // one counter per wait; the two long ones come from module parameters
   genvar gt;

   generate
      for (gt = 0; gt < N_TMR; gt++) begin : g_tmr
         localparam int CYC = (gt == T_READ) ? READ_TMO_CYC :
                              (gt == T_CMD) ? CMD_TMO_CYC :
                              (gt == T_SEL) ? `SELECT_TMO_CYC : `SSYNC_TMO_CYC;

         err_timeout_timer #(
            .CYCLES(CYC),
            .W(16)
         ) u_tmr (
            .ref_clk(ref_clk),
            .rst(rst),
            .clr(init_clr),
            .start(tmr_start[gt]),
            .stop(tmr_stop[gt]),
            .expired(tmr_exp[gt])
         );

      end
   endgenerate

   // ****************************************
   // parity checkers
   // ****************************************

   // map checker: defeat feeds zeros in place of the stored parity bits
   genvar gm;
   generate
      for (gm = 0; gm < 2; gm++) begin : g_map_par

         assign map_par_seen[gm] = dma_ctx.map_par[gm] & ~s_reg.diag[`DG_MAP_PAR_DEFEAT - `DG_LSB]; // RULE_19
         assign map_byte_bad[gm] = ~(^{dma_ctx.map_hi[gm*8 +: 8], map_par_seen[gm]}); // RULE_20
      end
   endgenerate

   // path checker: defeat blocks the stored parity so an even byte fails
   genvar gp;
   generate
      for (gp = 0; gp < 4; gp++) begin : g_path_par

         assign path_par_seen[gp] = dma_ctx.path_par[gp] & ~s_reg.diag[`DG_PATH_PAR_DEFEAT - `DG_LSB]; // RULE_21
         assign path_byte_bad[gp] = ~(^{dma_ctx.path_data[gp*8 +: 8], path_par_seen[gp]}); // RULE_20
      end
   endgenerate

   // ****************************************
   // map disable decode
   // ****************************************

   // the disable field counts groups of sixteen entries starting at zero
   // entries below the limit are ignored, not flagged
   assign map_dis_limit = {1'b0, control_reg[`CR_MAP_DIS_LSB +: 5], 4'h0};
   assign map_disabled = ({1'b0, dma_ctx.map_index} < map_dis_limit);

   // ****************************************
   // error events
   // ****************************************

   always_comb begin
      dma_ev = '0;

      // read data never arrived
      dma_ev[`ST_READ_TIMEOUT] = tmr_exp[T_READ]; // RULE_01

      // substitute response to a dma read
      dma_ev[`ST_SUBSTITUTE] = sbi_resp.rd_substitute & not_prefetch; // RULE_02

      // error confirmation, prefetch excluded
      dma_ev[`ST_CMD_ERROR] = sbi_resp.cmd_err & not_prefetch; // RULE_04

      // command stuck, only for buffered write, purge, or buffered read whose device still waits
      dma_ev[`ST_CMD_TIMEOUT] = tmr_exp[T_CMD] &
                                ((dma_ctx.op == OP_BUF_WRITE) || (dma_ctx.op == OP_PURGE) ||
                                 ((dma_ctx.op == OP_BUF_READ) && !dma_ctx.dev_timed_out)); // RULE_05

      // buffered storage parity during buffered read, write or purge
      dma_ev[`ST_PATH_PARITY] = dma_ctx.path_check & (|path_byte_bad) &
                                ((dma_ctx.op == OP_BUF_READ) || (dma_ctx.op == OP_BUF_WRITE) ||
                                 (dma_ctx.op == OP_PURGE)); // RULE_06

      // disabled entries are not recognised at all, so they raise nothing
      dma_ev[`ST_INVALID_MAP] = dma_ctx.map_check & !map_disabled & !dma_ctx.map_valid &
                                not_prefetch; // RULE_07
      dma_ev[`ST_MAP_PARITY] = dma_ctx.map_check & !map_disabled & (|map_byte_bad) &
                               not_prefetch; // RULE_08
   end

   // software-side timeout events
   always_comb begin
      sw_ev = '0;

      sw_ev[`ST_SELECT_TIMEOUT] = tmr_exp[T_SEL]; // RULE_12
      sw_ev[`ST_SSYNC_TIMEOUT] = tmr_exp[T_SSYN]; // RULE_13
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic dma_locked;
      logic sw_locked;
      logic [`ST_WIDTH-1:0] st;
      logic [3:0] dg;

      dma_locked = |(s_reg.status & `ST_DMA_GROUP);
      sw_locked = |(s_reg.status & `ST_SW_GROUP);

      st = s_reg.status;
      dg = s_reg.diag;
      s_next = s_reg;
      s_next.err = 1'b0;
      s_next.suppress = 1'b0;

      // software clears flags by writing ones; zeros leave them alone
      if (reg_req.wr && (reg_req.addr == `OFS_STATUS)) begin
         st = st & ~reg_req.wdata[`ST_WIDTH-1:0]; // RULE_22 RULE_14
      end

      // diagnostic bits are plain read/write
      if (reg_req.wr && (reg_req.addr == `OFS_DIAG)) begin
         dg = reg_req.wdata[`DG_SPARE:`DG_LSB]; // RULE_17 RULE_18 RULE_19 RULE_21
      end

      // capture registers refuse writes with an error answer
      if (reg_req.wr && ((reg_req.addr == `OFS_MCAP_A) || (reg_req.addr == `OFS_MCAP_B) ||
                         (reg_req.addr == `OFS_ACAP_A) || (reg_req.addr == `OFS_ACAP_B))) begin
         s_next.err = 1'b1;
      end

      // corrected data stands outside the locking group
      if (sbi_resp.rd_corrected && dma_read_op) begin
         st[`ST_CORRECTED] = 1'b1; // RULE_03
      end

      // sets are applied after the clear so an event in the clear cycle survives;
      // locked state is judged on the old flags, so a clear does not unlock early
      if (|dma_ev) begin
         if (!dma_locked) begin
            st = st | dma_ev; // RULE_09
            s_next.mcap = dma_ctx.map_index; // RULE_09
         end else begin
            st[`ST_LOST_ERROR] = 1'b1; // RULE_11
         end
      end

      // second group: a new timeout while one stands is simply dropped
      if ((|sw_ev) && !sw_locked) begin
         st = st | sw_ev; // RULE_14
         s_next.acap = sw_ctx.addr_hi; // RULE_16
      end

      // substitute data is never passed to the waiting device
      s_next.suppress = dma_ev[`ST_SUBSTITUTE]; // RULE_02

      // init and bus dead clear flags and diagnostics, captures hold
      if (init_clr) begin
         st = `ST_RESET;
         dg = `DG_RESET; // RULE_17 RULE_18 RULE_19 RULE_21
      end

      s_next.status = st;
      s_next.diag = dg;

      // interrupt lines track flags and enables; lost and corrected never interrupt
      s_next.dma_irq = control_reg[`CR_DMA_IRQ_EN] & (|(st & `ST_DMA_GROUP)); // RULE_10 RULE_11 RULE_23 RULE_24

      s_next.sw_irq = control_reg[`CR_SW_IRQ_EN] & (|(st & `ST_SW_GROUP)); // RULE_15 RULE_23 RULE_24

      // read data: registered, unmapped offsets answer zero
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            `OFS_STATUS: s_next.rdata = {21'h0, s_reg.status};
            `OFS_DIAG: s_next.rdata = {s_reg.diag, 28'h0};
            `OFS_MCAP_A, `OFS_MCAP_B: s_next.rdata = {23'h0, s_reg.mcap};
            `OFS_ACAP_A, `OFS_ACAP_B: s_next.rdata = {16'h0, s_reg.acap};
            default: s_next.rdata = 32'h0;
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************

   // power-up clears everything, captures included
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // outputs, all straight from flops
   // ****************************************

   assign reg_rdata = s_reg.rdata;
   assign reg_err = s_reg.err;

   assign dma_err_irq = s_reg.dma_irq;
   assign sw_err_irq = s_reg.sw_irq;

   // the interrupt front end drops peripheral requests while this stands
   assign interrupt_ignore_bit = s_reg.diag[`DG_INTR_IGNORE - `DG_LSB]; // RULE_18

   assign read_data_suppress = s_reg.suppress;

   assign failed_map_entry_capture = s_reg.mcap;
   assign failed_address_capture = s_reg.acap;

endmodule // adaptor_error_diag_status

// file: tb/adaptor_error_diag_status_assertions.sv
// port-level checks of the adaptor error and diagnostic block
`timescale 1ns/1ps
`include "adaptor_err_regs.svh"
module adaptor_error_diag_status_assertions import adaptor_err_pkg::*; (
   input logic ref_clk,
   input logic rst,
   input logic adaptor_init,
   input logic bus_dead,
   input logic [31:0] control_reg,
   input reg_req_t reg_req,
   input sbi_resp_t sbi_resp,
   input dma_ctx_t dma_ctx,
   input sw_ctx_t sw_ctx,
   input logic [31:0] reg_rdata,
   input logic reg_err,
   input logic dma_err_irq,
   input logic sw_err_irq,
   input logic interrupt_ignore_bit,
   input logic read_data_suppress,
   input logic [8:0] failed_map_entry_capture,
   input logic [15:0] failed_address_capture
);
   // ******
   // properties
   // ******
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // init beats events, so init cycles are left out
   wire init_any = adaptor_init | bus_dead;
   wire cap_wr = reg_req.wr && reg_req.addr inside {`OFS_MCAP_A, `OFS_ACAP_A, `OFS_MCAP_B, `OFS_ACAP_B};
   dma_irq_gate_a: assert property (!control_reg[`CR_DMA_IRQ_EN] |=> !dma_err_irq)
      else $error("dma irq while disabled");
   sw_irq_gate_a: assert property (!control_reg[`CR_SW_IRQ_EN] |=> !sw_err_irq)
      else $error("sw irq while disabled");
   cmd_err_irq_a: assert property (sbi_resp.cmd_err && dma_ctx.op != OP_PREFETCH && !init_any
      && control_reg[`CR_DMA_IRQ_EN] |=> dma_err_irq) else $error("no irq on command error");
   subst_hold_a: assert property (sbi_resp.rd_substitute && dma_ctx.op != OP_PREFETCH |=> read_data_suppress)
      else $error("substitute not withheld");
   hold_cause_a: assert property (read_data_suppress |-> $past(sbi_resp.rd_substitute))
      else $error("stray withhold");
   ignore_bit_wr_a: assert property (reg_req.wr && reg_req.addr == `OFS_DIAG && !init_any
      |=> interrupt_ignore_bit == $past(reg_req.wdata[`DG_INTR_IGNORE])) else $error("ignore bit write lost");
   init_clears_a: assert property (init_any |=> !interrupt_ignore_bit && !dma_err_irq && !sw_err_irq)
      else $error("init left state set");
   cap_write_err_a: assert property (reg_err == $past(cap_wr))
      else $error("capture write answer wrong");
   map_frozen_a: assert property (dma_err_irq |=> $stable(failed_map_entry_capture))
      else $error("map capture moved");
   addr_frozen_a: assert property (sw_err_irq |=> $stable(failed_address_capture))
      else $error("address capture moved");
   cover property ($rose(dma_err_irq));
   cover property ($rose(sw_err_irq));
   cover property (read_data_suppress);
endmodule // adaptor_error_diag_status_assertions

// file: tb/sbi_partner_model.sv
// behavioural system-bus memory answering the adaptor's commands
`timescale 1ns/1ps
module sbi_partner_model import adaptor_err_pkg::*; (
   input logic ref_clk,
   input logic rst,
   input logic cmd_sent,
   input logic [2:0] mode,
   input logic [3:0] delay,
   output sbi_resp_t sbi_resp
);
   // ******
   // mode 0 data, 1 error, 2 silent, 3 substitute, 4 corrected, 5 no data
   // ******
   int cnt;
   logic pend;
   // one command in flight; read data trails the acknowledge by a cycle
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt <= -1;
         pend <= 1'b0;
         sbi_resp <= '0;
      end else begin
         sbi_resp <= '0;
         pend <= 1'b0;
         if (cmd_sent) begin
            cnt <= int'(delay);
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end else if (cnt == 0) begin
            cnt <= -1;
            sbi_resp.cmd_err <= mode == 3'h1;
            sbi_resp.cmd_ack <= mode != 3'h1 && mode != 3'h2;
            pend <= 1'b1;
         end
         if (pend) begin
            sbi_resp.rd_data_ok <= mode == 3'h0;
            sbi_resp.rd_substitute <= mode == 3'h3;
            sbi_resp.rd_corrected <= mode == 3'h4;
         end
      end
   end
endmodule // sbi_partner_model

// file: tb/test_adaptor_error_diag_status.sv
// self-checking bench of the adaptor error and diagnostic block
`timescale 1ns/1ps
`include "adaptor_err_regs.svh"
module test_adaptor_error_diag_status import adaptor_err_pkg::*; ;
   // ******
   // stimulus and checks
   // ******
   localparam int TMO = 20;
   logic ref_clk = 1'b0, rst = 1'b1, adaptor_init = 1'b0, bus_dead = 1'b0, reg_err, dma_err_irq, sw_err_irq;
   logic interrupt_ignore_bit, read_data_suppress;
   logic [31:0] control_reg = '0, reg_rdata;
   logic [2:0] mode = '0;
   logic [3:0] delay = '0;
   logic [8:0] failed_map_entry_capture;
   logic [15:0] failed_address_capture;
   reg_req_t reg_req = '0;
   dma_ctx_t dma_ctx = '0;
   sw_ctx_t sw_ctx = '0;
   sbi_resp_t sbi_resp;
   int err_total = 0, checks_done = 0;
   adaptor_error_diag_status #(.READ_TMO_CYC(TMO), .CMD_TMO_CYC(TMO)) adaptor_error_diag_status_i (.*);
   sbi_partner_model sbi_partner_model_i (.ref_clk, .rst, .cmd_sent(dma_ctx.cmd_sent), .mode, .delay, .sbi_resp);
   initial forever #10 ref_clk = ~ref_clk;
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_req <= '{1'b0, 1'b1, a, d};
      @(posedge ref_clk);
      reg_req.wr <= 1'b0;
   endtask
   // read data stands from the edge after the request
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_req <= '{1'b1, 1'b0, a, 32'h0};
      @(posedge ref_clk);
      reg_req.rd <= 1'b0;
      @(posedge ref_clk);
      #1 chk(reg_rdata, e);
   endtask
   // odd parity over each byte: the nine bits hold an odd count of ones
   function automatic logic [3:0] par(input logic [31:0] d);
      for (int n = 0; n < 4; n++) par[n] = ~^d[8*n+:8];
   endfunction
   function automatic logic [31:0] exp_st(input op_kind_t op, input logic [2:0] m);
      if (op == OP_PREFETCH) return 32'h0;
      case (m)
         3'h1: return 32'h1 << `ST_CMD_ERROR;
         3'h2: return 32'h1 << `ST_CMD_TIMEOUT;
         3'h3: return 32'h1 << `ST_SUBSTITUTE;
         3'h4: return 32'h1 << `ST_CORRECTED;
         3'h5: return 32'h1 << `ST_READ_TIMEOUT;
         default: return 32'h0;
      endcase
   endfunction
   task automatic cmd(input op_kind_t op, input logic [2:0] m);
      @(posedge ref_clk);
      dma_ctx.op <= op;
      dma_ctx.cmd_is_read <= m != 3'h2;
      mode <= m;
      delay <= 4'($urandom_range(1, 6));
      dma_ctx.cmd_sent <= 1'b1;
      @(posedge ref_clk);
      dma_ctx.cmd_sent <= 1'b0;
      tick(TMO + 20);
   endtask
   task automatic ev(input logic path, input logic [8:0] x, input logic v, input logic [31:0] d, input logic [3:0] pe);
      logic [3:0] p;
      p = par(d) ^ pe;
      @(posedge ref_clk);
      dma_ctx.map_index <= x;
      dma_ctx.map_valid <= v;
      dma_ctx.map_hi <= d[15:0];
      dma_ctx.map_par <= p[1:0];
      dma_ctx.path_data <= d;
      dma_ctx.path_par <= p;
      dma_ctx.map_check <= !path;
      dma_ctx.path_check <= path;
      @(posedge ref_clk);
      dma_ctx.map_check <= 1'b0;
      dma_ctx.path_check <= 1'b0;
      tick(2);
   endtask
   task automatic swp(input int k);
      @(posedge ref_clk);
      sw_ctx.npr_issued <= k == 0;
      sw_ctx.msyn_start <= k == 1;
      sw_ctx.bus_granted <= k == 2;
      sw_ctx.ssyn_seen <= k == 3;
      @(posedge ref_clk);
      sw_ctx[19:16] <= 4'h0;
   endtask
   // a hang counts as a mismatch
   initial begin
      tick(20000);
      err_total++;
      final_report();
   end
   initial begin
      op_kind_t op;
      logic [2:0] m;
      logic [31:0] d;
      logic [8:0] x;
      logic [4:0] f;
      logic [15:0] a;
      logic en;
      d = $urandom(71175);
      tick(16);
      rst <= 1'b0;
      control_reg <= 32'h18;
      rchk(`OFS_STATUS, 32'h0);
      rchk(`OFS_DIAG, 32'h0);
      cmd(OP_DIRECT, 3'h5);
      rchk(`OFS_STATUS, 32'h400);
      cmd(OP_PURGE, 3'h1);
      rchk(`OFS_STATUS, 32'h404);
      wr(`OFS_STATUS, 32'h0);
      rchk(`OFS_STATUS, 32'h404);
      wr(`OFS_STATUS, 32'h400);
      rchk(`OFS_STATUS, 32'h4);
      chk(32'(dma_err_irq), 32'h0);
      // each response kind, qualifying op then prefetch
      for (int i = 0; i < 12; i++) begin
         wr(`OFS_STATUS, 32'h7FF);
         m = 3'(i % 6);
         en = 1'($urandom_range(0, 1));
         control_reg[4] <= en;
         op = $urandom_range(0, 1) ? (m == 3'h2 ? OP_PURGE : OP_BUF_READ) : (m == 3'h2 ? OP_BUF_WRITE : OP_DIRECT);
         if (i >= 6) op = OP_PREFETCH;
         cmd(op, m);
         rchk(`OFS_STATUS, exp_st(op, m));
         chk(32'(dma_err_irq), 32'(en && (exp_st(op, m) & 32'h6F8) != 0));
      end
      control_reg[4] <= 1'b1;
      wr(`OFS_STATUS, 32'h7FF);
      f = 5'($urandom_range(1, 3));
      control_reg[30:26] <= f;
      dma_ctx.op <= OP_BUF_WRITE;
      d = $urandom;
      ev(1'b1, 9'h0, 1'b1, d, 4'h0);
      rchk(`OFS_STATUS, 32'h0);
      ev(1'b1, 9'h0, 1'b1, d, 4'(1 << $urandom_range(0, 3)));
      rchk(`OFS_STATUS, 32'h20);
      wr(`OFS_STATUS, 32'h7FF);
      ev(1'b0, {f, 4'h0} - 9'h1, 1'b0, d, 4'h0);
      rchk(`OFS_STATUS, 32'h0);
      x = {f, 4'h0} + 9'($urandom_range(0, 14));
      ev(1'b0, x, 1'b0, d, 4'h0);
      rchk(`OFS_STATUS, 32'h10);
      ev(1'b0, x + 9'h1, 1'b0, d, 4'h0);
      rchk(`OFS_STATUS, 32'h14);
      wr(`OFS_MCAP_A, 32'hFFFF_FFFF);
      rchk(`OFS_MCAP_A, 32'(x));
      wr(`OFS_STATUS, 32'h7FF);
      ev(1'b0, x, 1'b1, d, 4'h2);
      rchk(`OFS_STATUS, 32'h8);
      wr(`OFS_STATUS, 32'h7FF);
      wr(`OFS_DIAG, 32'h2000_0000);
      ev(1'b0, x, 1'b1, 32'h0, 4'h0);
      rchk(`OFS_STATUS, 32'h8);
      wr(`OFS_STATUS, 32'h7FF);
      wr(`OFS_DIAG, 32'h1000_0000);
      ev(1'b1, x, 1'b1, 32'h0, 4'h0);
      rchk(`OFS_STATUS, 32'h20);
      wr(`OFS_DIAG, 32'hFFFF_FFFF);
      rchk(`OFS_DIAG, 32'hF000_0000);
      chk(32'(interrupt_ignore_bit), 32'h1);
      @(posedge ref_clk);
      if ($urandom_range(0, 1)) bus_dead <= 1'b1;
      else adaptor_init <= 1'b1;
      @(posedge ref_clk);
      bus_dead <= 1'b0;
      adaptor_init <= 1'b0;
      rchk(`OFS_DIAG, 32'h0);
      rchk(12'h3F0, 32'h0);
      // software timers: 2500 and 640 cycles
      a = 16'($urandom);
      sw_ctx.addr_hi <= a;
      swp(0);
      tick(2510);
      rchk(`OFS_STATUS, 32'h2);
      chk(32'(sw_err_irq), 32'h1);
      chk(32'(failed_address_capture), 32'(a));
      sw_ctx.addr_hi <= ~a;
      swp(1);
      tick(650);
      rchk(`OFS_STATUS, 32'h2);
      chk(32'(failed_address_capture), 32'(a));
      wr(`OFS_STATUS, 32'h2);
      swp(1);
      tick(650);
      rchk(`OFS_STATUS, 32'h1);
      chk(32'(failed_address_capture), {16'h0, ~a});
      wr(`OFS_STATUS, 32'h1);
      swp(1);
      tick(5);
      swp(3);
      swp(0);
      tick(3);
      swp(2);
      tick(2510);
      rchk(`OFS_STATUS, 32'h0);
      chk(32'(sw_err_irq), 32'h0);
      final_report();
   end
endmodule // test_adaptor_error_diag_status
bind adaptor_error_diag_status adaptor_error_diag_status_assertions assertions_i (.*);
